/* rtl/fcd_pkg.sv */
// package of constants for the flag-clear and decrement instruction block
package fcd_pkg;
	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_INSTR = 8'h00; // write: instruction word to execute
	localparam logic [7:0] OFF_PC = 8'h04; // program counter
	localparam logic [7:0] OFF_ACC = 8'h08; // acc[3:0], carry 4, zero 5, irq enable 6
	localparam logic [7:0] OFF_EVENT = 8'h0C; // event flags; write sets (peripheral model)
	localparam logic [7:0] OFF_PRESC = 8'h10; // prescaler zero, 14 bits
	localparam logic [7:0] OFF_WDOG = 8'h14; // watchdog counter; bit 31 slow clock select
	localparam logic [7:0] OFF_PSTAT = 8'h18; // [0] port status zero, [7:4] serial status
	localparam logic [7:0] OFF_IRQ_ST = 8'h1C; // sticky events, write one to clear
	localparam logic [7:0] OFF_IRQ_MSK = 8'h20; // mask
	localparam logic [7:0] OFF_MEM_ADR = 8'h24; // data memory window address
	localparam logic [7:0] OFF_MEM_DAT = 8'h28; // data memory window data
	// ==========================================================
	// opcodes (16-bit instruction word)
	localparam logic [15:0] OP_CLR_PRESC = 16'h1700;
	localparam logic [15:0] OP_CLR_WDOG = 16'h17FF;
	localparam logic [7:0] OP_CLR_EVENT_HI = 8'h40; // low byte is mask
	localparam logic [15:0] OP_CLR_PSTAT0 = 16'h4400;
	localparam logic [15:0] OP_CLR_SERIAL = 16'h5500;
	localparam logic [11:0] OP_CLR_PARAM_HI = 12'h16D; // low nibble is operand
	localparam logic [15:0] OP_IRQ_DIS = 16'h5080;
	localparam logic [15:0] OP_IRQ_EN = 16'h50E0;
	localparam logic [8:0] OP_DEC_HI = 9'h095; // low 7 bits address
	localparam logic [8:0] OP_DSKNZ_HI = 9'h091;
	// ==========================================================
	// fields
	localparam int PARAM_WDOG_SLOW_BIT = 3;
	localparam int EVT_RESERVED_BIT = 3;
	localparam logic [7:0] EVT_VALID = 8'hF7;
	localparam int LOW_CLR_W = 4;
	localparam int PRESC_W = 14;
	localparam int WDOG_W = 18;
	localparam int IRQ_SKIP_BIT = 0;
	localparam int IRQ_DEC_ZERO_BIT = 1;
endpackage : fcd_pkg

/* rtl/fcd_sticky.sv */
// one sticky interrupt status bit with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module fcd_sticky (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// event and clear
	input wire logic set,
	input wire logic clr,
	output logic q
);
	// set wins so an event in the clearing cycle is kept
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= 1'b0;
		end else begin
			q <= set | (q & ~clr);
		end
	end
endmodule : fcd_sticky
`default_nettype wire

/* rtl/fcd_axil.sv */
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module fcd_axil (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// register side
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err,
	input wire logic wr_err
);
	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] aw;
		logic [31:0] wd;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} fcd_axil_t;
	fcd_axil_t s, next_s;
	logic do_wr;
	assign awready = ~s.aw_got & ~s.bv;
	assign wready = ~s.w_got & ~s.bv;
	assign arready = ~s.rv;
	assign do_wr = s.aw_got & s.w_got;
	assign wr_en = do_wr;
	assign wr_addr = s.aw;
	assign wr_data = s.wd;
	assign rd_addr = araddr;
	assign bvalid = s.bv;
	assign bresp = s.br;
	assign rvalid = s.rv;
	assign rdata = s.rd;
	assign rresp = s.rr;
	// partial-word writes are accepted as full words; registers are narrow
	always_comb begin
		next_s = s;
		if (awvalid && awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw = awaddr;
		end
		if (wvalid && wready) begin
			next_s.w_got = 1'b1;
			next_s.wd = wdata;
		end
		if (do_wr) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.bv = 1'b1;
			next_s.br = wr_err ? 2'h2 : 2'h0;
		end
		if (s.bv && bready) begin
			next_s.bv = 1'b0;
		end
		if (arvalid && arready) begin
			next_s.rv = 1'b1;
			next_s.rd = rd_data;
			next_s.rr = rd_err ? 2'h2 : 2'h0;
		end else if (s.rv && rready) begin
			next_s.rv = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : fcd_axil
`default_nettype wire

/* rtl/fcd_core.sv */
// instruction executor for flag clears, watchdog, decrement and interrupt enable
// ==========================================================
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module fcd_core #(
	parameter int MEM_DEPTH = 128
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// peripheral status
	output logic irq_accept_en,
	output logic wdog_slow_clk,
	output logic irq
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [10:0] pc;
		logic [3:0] acc;
		logic carry_bit;
		logic zero_bit;
		logic irq_en;
		logic skip_pend;
		logic [7:0] event_flags;
		logic [fcd_pkg::PRESC_W-1:0] prescaler_zero;
		logic [fcd_pkg::WDOG_W-1:0] wdog;
		logic wdog_slow;
		logic port_status_zero;
		logic [3:0] serial_status_reg;
		logic [1:0] mask;
		logic [6:0] mem_adr;
	} fcd_state_t;
	fcd_state_t s, next_s;
	logic [3:0] mem [MEM_DEPTH];
	logic wr_en, wr_err, rd_err;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [15:0] ins;
	logic exec, is_dec, is_dsk, mem_we;
	logic [6:0] mem_wa;
	logic [3:0] mem_wd, oprnd, dec_res;
	logic [1:0] st_q, st_set;
	// ==========================================================
	// bus front end
	fcd_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err),
		.wr_err(wr_err)
	);
	// ==========================================================
	// decode
	assign ins = wr_data[15:0];
	assign exec = wr_en && (wr_addr == fcd_pkg::OFF_INSTR);
	assign is_dec = ins[15:7] == fcd_pkg::OP_DEC_HI;
	assign is_dsk = ins[15:7] == fcd_pkg::OP_DSKNZ_HI;
	assign oprnd = mem[ins[6:0]];
	assign dec_res = oprnd - 4'h1;
	// a write to the memory window also lands here, so one write port
	always_comb begin
		mem_we = 1'b0;
		mem_wa = s.mem_adr;
		mem_wd = wr_data[3:0];
		if (exec && !s.skip_pend && (is_dec || is_dsk)) begin
			mem_we = 1'b1;
			mem_wa = ins[6:0];
			mem_wd = dec_res;
		end else if (wr_en && wr_addr == fcd_pkg::OFF_MEM_DAT) begin
			mem_we = 1'b1;
		end
	end
	always_ff @(posedge aclk) begin
		if (mem_we) begin
			mem[mem_wa] <= mem_wd;
		end
	end
	// ==========================================================
	// execution and register writes
	always_comb begin
		next_s = s;
		st_set = 2'h0;
		if (exec && s.skip_pend) begin
			next_s.skip_pend = 1'b0;
			next_s.pc = s.pc + 11'h001;
		end else if (exec) begin
			next_s.pc = s.pc + 11'h001;
			if (ins == fcd_pkg::OP_CLR_PRESC) begin
				next_s.prescaler_zero[fcd_pkg::LOW_CLR_W-1:0] = 4'h0;
			end
			if (ins == fcd_pkg::OP_CLR_WDOG) begin
				next_s.wdog[fcd_pkg::LOW_CLR_W-1:0] = 4'h0;
			end
			if (ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI) begin
				next_s.event_flags = s.event_flags & ~(ins[7:0] & fcd_pkg::EVT_VALID);
			end
			if (ins[15:4] == fcd_pkg::OP_CLR_PARAM_HI) begin
				next_s.wdog_slow = ins[fcd_pkg::PARAM_WDOG_SLOW_BIT];
			end
			if (ins == fcd_pkg::OP_CLR_PSTAT0) begin
				next_s.port_status_zero = 1'b0;
			end
			if (ins == fcd_pkg::OP_CLR_SERIAL) begin
				next_s.serial_status_reg = 4'h0;
			end
			if (ins == fcd_pkg::OP_IRQ_DIS) begin
				next_s.irq_en = 1'b0;
			end
			if (ins == fcd_pkg::OP_IRQ_EN) begin
				next_s.irq_en = 1'b1;
			end
			if (is_dec || is_dsk) begin
				next_s.acc = dec_res;
				next_s.carry_bit = (oprnd != 4'h0); // no borrow
				next_s.zero_bit = (dec_res == 4'h0);
				st_set[fcd_pkg::IRQ_DEC_ZERO_BIT] = (dec_res == 4'h0);
			end
			if (is_dsk && dec_res != 4'h0) begin
				next_s.skip_pend = 1'b1;
				st_set[fcd_pkg::IRQ_SKIP_BIT] = 1'b1;
			end
		end else if (wr_en) begin
			unique case (wr_addr)
				fcd_pkg::OFF_PC: next_s.pc = wr_data[10:0];
				fcd_pkg::OFF_ACC: begin
					next_s.acc = wr_data[3:0];
					next_s.carry_bit = wr_data[4];
					next_s.zero_bit = wr_data[5];
					next_s.irq_en = wr_data[6];
				end
				fcd_pkg::OFF_EVENT: next_s.event_flags = s.event_flags | wr_data[7:0];
				fcd_pkg::OFF_PRESC: next_s.prescaler_zero = wr_data[13:0];
				fcd_pkg::OFF_WDOG: begin
					next_s.wdog = wr_data[17:0];
					next_s.wdog_slow = wr_data[31];
				end
				fcd_pkg::OFF_PSTAT: begin
					next_s.port_status_zero = wr_data[0];
					next_s.serial_status_reg = wr_data[7:4];
				end
				fcd_pkg::OFF_IRQ_MSK: next_s.mask = wr_data[1:0];
				fcd_pkg::OFF_MEM_ADR: next_s.mem_adr = wr_data[6:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	// ==========================================================
	// sticky interrupt status: skip taken, decrement reached zero
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_st
			fcd_sticky u_st (
				.aclk(aclk),
				.aresetn(aresetn),
				.set(st_set[gi]),
				.clr(wr_en && wr_addr == fcd_pkg::OFF_IRQ_ST && wr_data[gi]),
				.q(st_q[gi])
			);
		end
	endgenerate
	assign irq = |(st_q & s.mask);
	assign irq_accept_en = s.irq_en;
	assign wdog_slow_clk = s.wdog_slow;
	// ==========================================================
	// read mux
	assign wr_err = 1'b0;
	always_comb begin
		rd_err = 1'b0;
		unique case (rd_addr)
			fcd_pkg::OFF_INSTR: rd_data = 32'h0;
			fcd_pkg::OFF_PC: rd_data = {21'h0, s.pc};
			fcd_pkg::OFF_ACC: rd_data = {25'h0, s.irq_en, s.zero_bit, s.carry_bit, s.acc};
			fcd_pkg::OFF_EVENT: rd_data = {24'h0, s.event_flags};
			fcd_pkg::OFF_PRESC: rd_data = {18'h0, s.prescaler_zero};
			fcd_pkg::OFF_WDOG: rd_data = {s.wdog_slow, 13'h0, s.wdog};
			fcd_pkg::OFF_PSTAT: rd_data = {24'h0, s.serial_status_reg, 3'h0, s.port_status_zero};
			fcd_pkg::OFF_IRQ_ST: rd_data = {30'h0, st_q};
			fcd_pkg::OFF_IRQ_MSK: rd_data = {30'h0, s.mask};
			fcd_pkg::OFF_MEM_ADR: rd_data = {25'h0, s.mem_adr};
			fcd_pkg::OFF_MEM_DAT: rd_data = {28'h0, mem[s.mem_adr]};
			default: begin
				rd_data = 32'h0;
				rd_err = 1'b1;
			end
		endcase
	end
	// ==========================================================
	// checks
	// antecedents leave out the swallowed word; a_skip_inert guards that one
	a_presc_low_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_CLR_PRESC |=> s.prescaler_zero[3:0] == 4'h0
		&& s.prescaler_zero[13:4] == $past(s.prescaler_zero[13:4]))
		else $error("prescaler low clear wrong");
	a_wdog_low_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_CLR_WDOG |=> s.wdog[3:0] == 4'h0
		&& s.wdog[17:4] == $past(s.wdog[17:4]))
		else $error("watchdog low clear wrong");
	a_event_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI
		|=> s.event_flags == ($past(s.event_flags) & ~($past(ins[7:0]) & 8'hF7)))
		else $error("event clear mask wrong");
	a_param_wdog: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:4] == fcd_pkg::OP_CLR_PARAM_HI
		|=> wdog_slow_clk == $past(ins[3]))
		else $error("watchdog clock select wrong");
	a_pstat_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_CLR_PSTAT0 |=> !s.port_status_zero)
		else $error("port status zero not cleared");
	a_serial_clr: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_CLR_SERIAL |=> s.serial_status_reg == 4'h0)
		else $error("serial status not cleared");
	a_dec_acc: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && (is_dec || is_dsk) |=> s.acc == $past(oprnd) - 4'h1
		&& s.zero_bit == (s.acc == 4'h0) && s.carry_bit == ($past(oprnd) != 4'h0))
		else $error("decrement result or flags wrong");
	a_irq_dis: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_IRQ_DIS |=> !irq_accept_en)
		else $error("interrupts not disabled");
	a_dsk_skip: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && is_dsk && dec_res != 4'h0
		|=> s.skip_pend && s.pc == $past(s.pc) + 11'h001)
		else $error("skip not armed after nonzero result");
	a_irq_en: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_IRQ_EN |=> irq_accept_en)
		else $error("interrupts not enabled");
	a_skip_inert: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && s.skip_pend |=> s.acc == $past(s.acc) && s.event_flags == $past(s.event_flags)
		&& s.irq_en == $past(s.irq_en) && !s.skip_pend && s.pc == $past(s.pc) + 11'h001
		&& s.prescaler_zero == $past(s.prescaler_zero) && s.wdog == $past(s.wdog))
		else $error("skipped instruction had effect");
	// one check per mask bit, bits 5 and 6 sharing one, so a miswired flag names itself
	a_evt_divider: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && ins[0]
		|=> !s.event_flags[0])
		else $error("divider overflow flag not cleared");
	a_evt_timer_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && ins[1]
		|=> !s.event_flags[1])
		else $error("timer zero underflow flag not cleared");
	a_evt_port_change: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && ins[2]
		|=> !s.event_flags[2])
		else $error("port change flag not cleared");
	a_evt_ext_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && ins[4]
		|=> !s.event_flags[4])
		else $error("external pin flag not cleared");
	a_evt_serial: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && (ins[5] || ins[6])
		|=> !($past(ins[5]) && s.event_flags[5]) && !($past(ins[6]) && s.event_flags[6]))
		else $error("serial event flag not cleared");
	a_evt_timer_one: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI && ins[7]
		|=> !s.event_flags[7])
		else $error("timer one underflow flag not cleared");
	a_evt_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins[15:8] == fcd_pkg::OP_CLR_EVENT_HI
		|=> s.event_flags[3] == $past(s.event_flags[3]))
		else $error("reserved event bit changed");
	// memory side of the decrement, the borrow at zero and the skip decision
	a_dec_mem: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && (is_dec || is_dsk)
		|=> mem[$past(ins[6:0])] == $past(dec_res))
		else $error("decrement result not stored");
	a_carry_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && (is_dec || is_dsk) && oprnd == 4'h0
		|=> s.acc == 4'hF && !s.carry_bit && !s.zero_bit)
		else $error("borrow from zero wrong");
	a_no_skip_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && is_dsk && dec_res == 4'h0
		|=> !s.skip_pend && s.pc == $past(s.pc) + 11'h001)
		else $error("skip armed on zero result");
	a_skip_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && s.skip_pend |-> !mem_we)
		else $error("skipped instruction wrote memory");
	// held state: only its own instruction or a register write may move it
	a_irq_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!irq_accept_en && !(exec && !s.skip_pend && ins == fcd_pkg::OP_IRQ_EN)
		&& !(wr_en && wr_addr == fcd_pkg::OFF_ACC) |=> !irq_accept_en)
		else $error("interrupts came back without enable");
	a_wdog_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!(exec && !s.skip_pend && ins[15:4] == fcd_pkg::OP_CLR_PARAM_HI)
		&& !(wr_en && wr_addr == fcd_pkg::OFF_WDOG) |=> $stable(wdog_slow_clk))
		else $error("watchdog clock select moved on its own");
	a_pstat_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		exec && !s.skip_pend && ins == fcd_pkg::OP_CLR_PSTAT0
		|=> s.serial_status_reg == $past(s.serial_status_reg))
		else $error("port status clear touched serial flags");
endmodule : fcd_core
`default_nettype wire

/* dv/test_flag_clear_and_decrement_ops.sv */
// self-checking bench for the flag-clear and decrement instruction block
`timescale 1ns/1ps
`default_nettype none
module test_flag_clear_and_decrement_ops;
	// ==========================================================
	// signals
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq_accept_en, wdog_slow_clk, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [31:0] exp_d[$], exp_m[$];
	logic [1:0] exp_r[$];
	logic [10:0] pc_m = 11'h000; // bench copy of the program counter
	logic [6:0] a;
	logic [3:0] v;
	logic [7:0] m;
	int errors = 0, num_checks = 0;
	always #2.5 aclk = ~aclk;
	fcd_core #(.MEM_DEPTH(128)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .irq_accept_en(irq_accept_en), .wdog_slow_clk(wdog_slow_clk), .irq(irq));
	// ==========================================================
	// comparison and verdict
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// ==========================================================
	// bus master; readiness is looked at on the falling edge, where it is settled
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bit ta, tw, tb;
		int n;
		n = 0;
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid && bready;
			if (tb) chk({30'h0, bresp}, 32'h0, "write response");
			@(posedge aclk);
			n++;
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
		end while (!tb && n < 100);
		if (!tb) chk(32'h1, 32'h0, "write answer missing");
		// a spare edge keeps the next call from raising what this one just lowered
		@(posedge aclk);
	endtask : wr
	// expectation goes on the queue; the monitor compares when the data turn up
	task automatic rd(input logic [7:0] ad, input logic [31:0] e, input logic [31:0] mk,
			input logic [1:0] r);
		bit ta, tr;
		int n;
		n = 0;
		exp_d.push_back(e & mk);
		exp_m.push_back(mk);
		exp_r.push_back(r);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid && arready;
			tr = rvalid && rready;
			@(posedge aclk);
			n++;
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
		end while (!tr && n < 100);
		if (!tr) chk(32'h1, 32'h0, "read answer missing");
		@(posedge aclk);
	endtask : rd
	// each executed word bumps the program counter by one, skipped ones too
	task automatic ex(input logic [15:0] op);
		wr(fcd_pkg::OFF_INSTR, {16'h0000, op});
		pc_m++;
	endtask : ex
	task automatic pchk(input logic [31:0] e, input string msg, input int sel);
		repeat (2) @(negedge aclk);
		chk({29'h0, irq, wdog_slow_clk, irq_accept_en} >> sel & 32'h1, e, msg);
		@(posedge aclk);
	endtask : pchk
	// ==========================================================
	// read monitor: one result per handshake, oldest note first
	always @(negedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1 && exp_d.size() > 0) begin
			chk(rdata & exp_m[0], exp_d[0], "read data");
			chk({30'h0, rresp}, {30'h0, exp_r[0]}, "read response");
			void'(exp_d.pop_front());
			void'(exp_m.pop_front());
			void'(exp_r.pop_front());
		end
	end
	// watchdog against a hung handshake
	initial begin
		#400000;
		errors++;
		conclude();
	end
	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(14));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		pchk(0, "accept after reset", 0);
		pchk(0, "slow clock after reset", 1);
		pchk(0, "irq after reset", 2);
		rd(8'h40, 0, 32'hFFFFFFFF, 2'h2); // unmapped place refuses
		$display("test reset done");
		// prescaler and watchdog low nibble clears
		wr(fcd_pkg::OFF_PRESC, 32'h3FFF);
		ex(fcd_pkg::OP_CLR_PRESC);
		rd(fcd_pkg::OFF_PRESC, 32'h3FF0, 32'h3FFF, 2'h0);
		wr(fcd_pkg::OFF_WDOG, 32'h3FFFF);
		ex(fcd_pkg::OP_CLR_WDOG);
		rd(fcd_pkg::OFF_WDOG, 32'h3FFF0, 32'h3FFFF, 2'h0);
		$display("test low clears done");
		// every single mask bit, then random masks; bit 3 never clears
		for (int i = 0; i < 12; i++) begin
			m = (i < 8) ? 8'h01 << i : 8'($urandom());
			wr(fcd_pkg::OFF_EVENT, 32'hFF);
			ex({fcd_pkg::OP_CLR_EVENT_HI, m});
			rd(fcd_pkg::OFF_EVENT, {24'h0, 8'hFF & ~(m & 8'hF7)}, 32'hFF, 2'h0);
		end
		$display("test event clear done");
		// watchdog clock option; reserved operand bits carry no weight
		ex({fcd_pkg::OP_CLR_PARAM_HI, 4'h8});
		pchk(1, "slow clock set", 1);
		ex({fcd_pkg::OP_CLR_PARAM_HI, 4'h7});
		pchk(0, "slow clock clear", 1);
		// port and serial status clears
		wr(fcd_pkg::OFF_PSTAT, 32'hF1);
		ex(fcd_pkg::OP_CLR_PSTAT0);
		rd(fcd_pkg::OFF_PSTAT, 0, 32'h01, 2'h0);
		ex(fcd_pkg::OP_CLR_SERIAL);
		rd(fcd_pkg::OFF_PSTAT, 0, 32'hF0, 2'h0);
		$display("test option and status done");
		// decrement over every nibble value, wrap at zero included
		for (int i = 0; i < 16; i++) begin
			a = 7'($urandom());
			v = 4'(i);
			wr(fcd_pkg::OFF_MEM_ADR, {25'h0, a});
			wr(fcd_pkg::OFF_MEM_DAT, {28'h0, v});
			ex({fcd_pkg::OP_DEC_HI, a});
			rd(fcd_pkg::OFF_MEM_DAT, {28'h0, v - 4'h1}, 32'hF, 2'h0);
			rd(fcd_pkg::OFF_ACC, {26'h0, v == 4'h1, v != 4'h0, v - 4'h1}, 32'h3F, 2'h0);
		end
		$display("test decrement done");
		// skip taken: the enable after it must change nothing
		wr(fcd_pkg::OFF_IRQ_ST, 32'h3);
		// start near the top so the skip also crosses the counter wrap
		wr(fcd_pkg::OFF_PC, 32'h7FE);
		pc_m = 11'h7FE;
		wr(fcd_pkg::OFF_MEM_DAT, 32'h2);
		ex({fcd_pkg::OP_DSKNZ_HI, a});
		rd(fcd_pkg::OFF_ACC, 32'h11, 32'h3F, 2'h0);
		ex(fcd_pkg::OP_IRQ_EN);
		pchk(0, "skipped enable", 0);
		rd(fcd_pkg::OFF_PC, {21'h0, pc_m}, 32'h7FF, 2'h0);
		// no skip on a zero result: the enable runs
		ex({fcd_pkg::OP_DSKNZ_HI, a});
		rd(fcd_pkg::OFF_MEM_DAT, 0, 32'hF, 2'h0);
		ex(fcd_pkg::OP_IRQ_EN);
		pchk(1, "enable", 0);
		ex(fcd_pkg::OP_IRQ_DIS);
		pchk(0, "disable", 0);
		rd(fcd_pkg::OFF_PC, {21'h0, pc_m}, 32'h7FF, 2'h0);
		$display("test skip and enable done");
		// interrupt: sticky bits, mask, write one to clear
		rd(fcd_pkg::OFF_IRQ_ST, 32'h3, 32'h3, 2'h0);
		wr(fcd_pkg::OFF_IRQ_MSK, 32'h0);
		pchk(0, "masked", 2);
		wr(fcd_pkg::OFF_IRQ_MSK, 32'h1);
		pchk(1, "skip event", 2);
		wr(fcd_pkg::OFF_IRQ_ST, 32'h1);
		pchk(0, "skip cleared", 2);
		wr(fcd_pkg::OFF_IRQ_MSK, 32'h3);
		pchk(1, "zero event", 2);
		wr(fcd_pkg::OFF_IRQ_ST, 32'h2);
		pchk(0, "zero cleared", 2);
		$display("test interrupt done");
		repeat (4) @(posedge aclk);
		conclude();
	end
endmodule : test_flag_clear_and_decrement_ops
`default_nettype wire
